/* rtl/sas_pkg.sv */
package sas_pkg;
   localparam int RES_BITS     = 10;
   localparam int EXTRA_PERIODS = 2;
   localparam int CONV_PERIODS = RES_BITS + EXTRA_PERIODS;
   localparam int BUF_WORDS    = 16;
   localparam int HALF_WORDS   = 8;
   localparam int CHANNELS     = 16;
   localparam logic [1:0] FMT_UINT_RIGHT = 2'h0;
   localparam logic [1:0] FMT_SINT_RIGHT = 2'h1;
   localparam logic [1:0] FMT_UINT_LEFT  = 2'h2;
   localparam logic [1:0] FMT_SINT_LEFT  = 2'h3;
   localparam logic [1:0] TRIG_SOFT = 2'h0;
   localparam logic [1:0] TRIG_HW   = 2'h1;
   localparam logic [1:0] TRIG_AUTO = 2'h2;
   localparam logic [1:0] TRIG_FREE = 2'h3;
   localparam logic [1:0] SEQ_SINGLE = 2'h0;
   localparam logic [1:0] SEQ_ALT    = 2'h1;
   localparam logic [1:0] SEQ_SCAN   = 2'h2;
   typedef enum logic [1:0] {SAS_INACTIVE, SAS_SAMPLE, SAS_CONVERT} sas_state_t;
endpackage

/* rtl/sas_sequencer.sv */
`timescale 1ns/1ps
// Contract
// RL1: Each conversion takes one period per bit plus two, twelve periods total.
// RL2: Ten-bit result formatted signed or unsigned, left or right justified.
// RL3: Each result goes to the sixteen-word store at successive locations.
// RL4: Optionally the store splits into two eight-word halves.
// RL5: Interrupt flag sets after one through sixteen conversions.
// RL6: On interrupt the write pointer and scan position return to start.
// RL7: A trigger ends sampling and starts a conversion or repeating sequence.
// RL8: Starts by software, free running, or a selected hardware event.
// RL9: Auto trigger uses a counter on the converter clock for intervals.
// RL10: Auto sampling alternates sample and convert, paced by the trigger.
// RL11: Inactive before setup and after software conversions, never with auto sampling.
// RL12: Convert entered at once after sample, left when conversion finishes.
// RL13: Single channel, two-channel alternation, or bit-map scan sequences.
// RL14: With scanning on, the next channel is chosen by hardware.
// RL15: A completed result is stored; sampling may restart, interrupt raised.
// RL16: Sampling start and end are each hardware or software controlled.
// RL17: Software configures a sampling time long enough and throughput-aware.
// RL18: Channel select codes cover up to sixteen inputs.
// RL19: Result store is read-only; nothing writes it from software.
// RL20: Reset gives inactive state, pointer zero, scan start, counter clear.
// RL21: Sample-enable output is high only in the sample state.
module sas_sequencer #(
   parameter int RES_BITS = sas_pkg::RES_BITS,
   parameter int CHANNELS = sas_pkg::CHANNELS,
   parameter int BUF_WORDS = sas_pkg::BUF_WORDS
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        conv_clk_en,
   input  wire logic        enable,
   input  wire logic        auto_sample,
   input  wire logic        sample_start,
   input  wire logic [1:0]  trig_sel,
   input  wire logic        soft_convert,
   input  wire logic        hw_event,
   input  wire logic [4:0]  auto_periods,
   input  wire logic [1:0]  seq_mode,
   input  wire logic [3:0]  chan_a,
   input  wire logic [3:0]  chan_b,
   input  wire logic [15:0] scan_map,
   input  wire logic [1:0]  format,
   input  wire logic        split_buf,
   input  wire logic [3:0]  irq_count,
   input  wire logic        irq_clear,
   input  wire logic        cmp_in,
   input  wire logic [3:0]  rd_addr,
   output logic             sample_en,
   output logic             dac_load,
   output logic [9:0]       sar_code,
   output logic [3:0]       chan_sel,
   output logic             irq_flag,
   output logic             half_fill,
   output logic             busy,
   output logic [15:0]      rd_data
);
   sas_pkg::sas_state_t state;
   logic [15:0] store [BUF_WORDS];
   logic [3:0]  conv_cnt;
   logic [4:0]  auto_cnt;
   logic [3:0]  wr_ptr;
   logic [3:0]  done_cnt;
   logic        alt_sel;
   logic [3:0]  scan_pos;
   logic [9:0]  result;
   logic        trigger;
   logic        conv_done;
   logic [3:0]  next_scan;
   logic [15:0] fmt_word;
   logic [3:0]  first_scan;

   // The auto counter reaching its target counts as a trigger.
   always_comb
   begin
      case (trig_sel)
         sas_pkg::TRIG_SOFT: trigger = soft_convert; // RL8
         sas_pkg::TRIG_HW:   trigger = hw_event; // RL8
         sas_pkg::TRIG_AUTO: trigger = conv_clk_en && (auto_cnt >= auto_periods); // RL9
         sas_pkg::TRIG_FREE: trigger = conv_clk_en; // RL8
         default:            trigger = 1'b0;
      endcase
   end

   assign conv_done = conv_clk_en && (conv_cnt == 4'(sas_pkg::CONV_PERIODS - 1)); // RL1

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         auto_cnt <= 5'h00;
      else if (state != sas_pkg::SAS_SAMPLE)
         auto_cnt <= 5'h00;
      else if (conv_clk_en && auto_cnt != 5'h1f)
         auto_cnt <= auto_cnt + 5'h01; // RL9
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         state <= sas_pkg::SAS_INACTIVE; // RL20
      else if (!enable)
         state <= sas_pkg::SAS_INACTIVE; // RL11
      else
      begin
         case (state)
            sas_pkg::SAS_INACTIVE:
               if (auto_sample || sample_start)
                  state <= sas_pkg::SAS_SAMPLE; // RL16
            sas_pkg::SAS_SAMPLE:
               if (trigger)
                  state <= sas_pkg::SAS_CONVERT; // RL7 RL12
            sas_pkg::SAS_CONVERT:
               if (conv_done)
                  state <= auto_sample ? sas_pkg::SAS_SAMPLE : sas_pkg::SAS_INACTIVE; // RL10 RL11 RL12
            default:
               state <= sas_pkg::SAS_INACTIVE;
         endcase
      end
   end

   // Successive approximation: one bit is resolved per converter period, two trailing periods.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         conv_cnt <= 4'h0;
         sar_code <= 10'h000;
         result   <= 10'h000;
      end
      else if (state != sas_pkg::SAS_CONVERT)
      begin
         conv_cnt <= 4'h0;
         sar_code <= 10'h200;
      end
      else if (conv_clk_en)
      begin
         conv_cnt <= conv_done ? 4'h0 : conv_cnt + 4'h1; // RL1
         if (conv_cnt < 4'(RES_BITS))
         begin
            if (!cmp_in)
               sar_code[4'(RES_BITS - 1) - conv_cnt] <= 1'b0;
            if (conv_cnt != 4'(RES_BITS - 1))
               sar_code[4'(RES_BITS - 2) - conv_cnt] <= 1'b1;
         end
         if (conv_cnt == 4'(RES_BITS))
            result <= sar_code; // RL1
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         dac_load <= 1'b0;
      else
         dac_load <= (state == sas_pkg::SAS_CONVERT) && conv_clk_en;
   end

   always_comb
   begin
      case (format)
         sas_pkg::FMT_UINT_RIGHT: fmt_word = {6'h00, result}; // RL2
         sas_pkg::FMT_SINT_RIGHT: fmt_word = {{6{~result[9]}}, ~result[9], result[8:0]}; // RL2
         sas_pkg::FMT_UINT_LEFT:  fmt_word = {result, 6'h00}; // RL2
         sas_pkg::FMT_SINT_LEFT:  fmt_word = {~result[9], result[8:0], 6'h00}; // RL2
         default:                 fmt_word = {6'h00, result};
      endcase
   end

   // Only the conversion path writes the store; there is no software write port.
   always_ff @(posedge clk)
   begin
      if (conv_done && state == sas_pkg::SAS_CONVERT)
         store[wr_ptr] <= fmt_word; // RL3 RL15 RL19
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rd_data <= 16'h0000;
      else
         rd_data <= store[rd_addr];
   end

   // Pointer, counter and interrupt flag; a new completion wins over a clear.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_ptr    <= 4'h0; // RL20
         done_cnt  <= 4'h0; // RL20
         irq_flag  <= 1'b0;
         half_fill <= 1'b0;
      end
      else if (conv_done && state == sas_pkg::SAS_CONVERT)
      begin
         if (done_cnt == irq_count)
         begin
            irq_flag <= 1'b1; // RL5 RL15
            done_cnt <= 4'h0;
            if (split_buf)
            begin
               half_fill <= ~half_fill; // RL4
               wr_ptr    <= half_fill ? 4'h0 : 4'(sas_pkg::HALF_WORDS); // RL4
            end
            else
               wr_ptr <= 4'h0; // RL6
         end
         else
         begin
            done_cnt <= done_cnt + 4'h1;
            wr_ptr   <= wr_ptr + 4'h1; // RL3
         end
      end
      else if (irq_clear)
         irq_flag <= 1'b0;
   end

   always_comb
   begin
      next_scan  = scan_pos;
      first_scan = 4'h0;
      for (int i = CHANNELS - 1; i >= 0; i--)
         if (scan_map[i])
            first_scan = 4'(i);
      for (int i = CHANNELS - 1; i >= 0; i--)
         if (scan_map[i] && 4'(i) > scan_pos)
            next_scan = 4'(i); // RL14
      if (next_scan == scan_pos)
         next_scan = first_scan;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         scan_pos <= 4'h0; // RL20
      else if (seq_mode != sas_pkg::SEQ_SCAN)
         scan_pos <= first_scan;
      else if (conv_done && state == sas_pkg::SAS_CONVERT)
         scan_pos <= (done_cnt == irq_count) ? first_scan : next_scan; // RL6 RL14
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         alt_sel <= 1'b0;
      else if (seq_mode == sas_pkg::SEQ_ALT && conv_done && state == sas_pkg::SAS_CONVERT)
         alt_sel <= (done_cnt == irq_count) ? 1'b0 : ~alt_sel; // RL6 RL13
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         chan_sel <= 4'h0;
      else
      begin
         case (seq_mode)
            sas_pkg::SEQ_SINGLE: chan_sel <= chan_a; // RL13 RL18
            sas_pkg::SEQ_ALT:    chan_sel <= alt_sel ? chan_b : chan_a; // RL13
            sas_pkg::SEQ_SCAN:   chan_sel <= scan_pos; // RL13 RL18
            default:             chan_sel <= chan_a;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sample_en <= 1'b0;
         busy      <= 1'b0;
      end
      else
      begin
         sample_en <= (state == sas_pkg::SAS_SAMPLE); // RL21
         busy      <= (state == sas_pkg::SAS_CONVERT);
      end
   end
endmodule

/* bench/sas_sequencer_chk.sv */
`timescale 1ns/1ps
module sas_sequencer_chk (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       conv_clk_en,
   input wire logic       enable,
   input wire logic       auto_sample,
   input wire logic [1:0] seq_mode,
   input wire logic [3:0] chan_a,
   input wire logic       irq_clear,
   input wire logic       sample_en,
   input wire logic [3:0] chan_sel,
   input wire logic       irq_flag,
   input wire logic       busy
);
   logic [4:0] cnt;
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         cnt <= 5'h0;
      else if (!busy || sample_en)
         cnt <= 5'h0;
      else if (conv_clk_en)
         cnt <= cnt + 5'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_reset_idle: assert property ($rose(resetn) |-> !sample_en && !busy && !irq_flag)
      else $error("outputs not idle after reset");
   chk_conv_bound: assert property (cnt <= 5'hc)
      else $error("conversion ran too long");
   chk_conv_entry: assert property ($fell(sample_en) && enable |-> busy)
      else $error("convert not entered after sample");
   chk_conv_ends: assert property (busy && !sample_en |-> ##[0:13] (!busy || sample_en))
      else $error("conversion did not end");
   chk_idle_off: assert property (!enable [*3] |-> !sample_en)
      else $error("sampling while disabled");
   chk_auto_pingpong: assert property (auto_sample && enable && $fell(busy) |-> ##[0:1] sample_en)
      else $error("auto mode did not resume sampling");
   chk_single_chan: assert property (seq_mode == sas_pkg::SEQ_SINGLE && sample_en |-> chan_sel == chan_a)
      else $error("single channel not selected");
   chk_chan_hold: assert property (busy && !sample_en ##1 busy && !sample_en |-> $stable(chan_sel))
      else $error("channel moved during conversion");
   chk_irq_clear: assert property (irq_clear |=> !irq_flag)
      else $error("flag not cleared");
endmodule
bind sas_sequencer sas_sequencer_chk i_chk (.clk(clk), .resetn(resetn), .conv_clk_en(conv_clk_en),
   .enable(enable), .auto_sample(auto_sample), .seq_mode(seq_mode), .chan_a(chan_a), .irq_clear(irq_clear),
   .sample_en(sample_en), .chan_sel(chan_sel), .irq_flag(irq_flag), .busy(busy));

/* bench/sas_analog_model.sv */
`timescale 1ns/1ps
module sas_analog_model (
   input  wire logic [9:0] sar_code,
   input  wire logic [3:0] chan_sel,
   input  wire logic       sample_en,
   output logic            cmp_in
);
   logic [9:0] held = 10'h0;
   // The hold capacitor tracks the selected input only while sampling.
   always @*
      if (sample_en)
         held = {chan_sel, 6'h2b};
   assign cmp_in = (held >= sar_code);
endmodule

/* bench/sas_sequencer_tb.sv */
`timescale 1ns/1ps
module sas_sequencer_tb;
   logic clk = 1'b0, resetn = 1'b0, en = 1'b0, aut = 1'b0, ss = 1'b0, sc = 1'b0, hw = 1'b0;
   logic spl = 1'b0, iclr = 1'b0, cmp, se, dl, irq, hf, busy;
   logic [1:0] trg = 2'h0, seq = 2'h0, fmt = 2'h0;
   logic [3:0] ca = 4'h0, cb = 4'h0, icnt = 4'h0, ra = 4'h0, cs;
   logic [15:0] map = 16'h0, rd;
   logic [9:0] code;
   int fail_count = 0, num_checks = 0;
   always #20 clk = ~clk;
   sas_sequencer i_dut (.clk(clk), .resetn(resetn), .conv_clk_en(1'b1), .enable(en), .auto_sample(aut),
      .sample_start(ss), .trig_sel(trg), .soft_convert(sc), .hw_event(hw), .auto_periods(5'h3),
      .seq_mode(seq), .chan_a(ca), .chan_b(cb), .scan_map(map), .format(fmt), .split_buf(spl),
      .irq_count(icnt), .irq_clear(iclr), .cmp_in(cmp), .rd_addr(ra), .sample_en(se), .dac_load(dl),
      .sar_code(code), .chan_sel(cs), .irq_flag(irq), .half_fill(hf), .busy(busy), .rd_data(rd));
   sas_analog_model i_ana (.sar_code(code), .chan_sel(cs), .sample_en(se), .cmp_in(cmp));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] level(input logic [3:0] ch, input logic [1:0] f);
      logic [9:0] v;
      v = {ch, 6'h2b};
      case (f)
         sas_pkg::FMT_UINT_RIGHT: level = {6'h0, v};
         sas_pkg::FMT_SINT_RIGHT: level = {{7{~v[9]}}, v[8:0]};
         sas_pkg::FMT_UINT_LEFT:  level = {v, 6'h0};
         default:                 level = {~v[9], v[8:0], 6'h0};
      endcase
   endfunction
   task automatic wait_irq();
      int n;
      for (n = 0; n < 200 && irq !== 1'b1; n++)
         @(negedge clk);
      check(irq, 1'b1);
   endtask
   task automatic read_chk(input logic [3:0] a, input logic [3:0] ch);
      ra = a;
      @(negedge clk);
      check(rd, level(ch, fmt));
   endtask
   task automatic clear_irq();
      iclr = 1'b1;
      @(negedge clk);
      iclr = 1'b0;
   endtask
   task automatic t_formats();
      int f;
      for (f = 0; f < 4; f++)
      begin
         fmt = f[1:0];
         ca = 4'h3 + f[3:0];
         trg = f[0] ? sas_pkg::TRIG_HW : sas_pkg::TRIG_SOFT;
         ss = 1'b1;
         @(negedge clk);
         ss = 1'b0;
         repeat (4) @(negedge clk);
         check(se, 1'b1);
         hw = f[0];
         sc = ~f[0];
         @(negedge clk);
         hw = 1'b0;
         sc = 1'b0;
         wait_irq();
         check(se, 1'b0);
         read_chk(4'h0, ca);
         clear_irq();
      end
      $display("test formats done");
   endtask
   task automatic t_scan();
      map = 16'h0224;
      @(negedge clk);
      seq = sas_pkg::SEQ_SCAN;
      icnt = 4'h3;
      trg = sas_pkg::TRIG_FREE;
      aut = 1'b1;
      wait_irq();
      read_chk(4'h0, 4'h2);
      read_chk(4'h1, 4'h5);
      read_chk(4'h2, 4'h9);
      read_chk(4'h3, 4'h2);
      aut = 1'b0;
      clear_irq();
      repeat (20) @(negedge clk);
      $display("test scan done");
   endtask
   task automatic t_split();
      resetn = 1'b0;
      en = 1'b0;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      repeat (3) @(negedge clk);
      check({se, busy, irq, hf}, 4'h0);
      en = 1'b1;
      seq = sas_pkg::SEQ_ALT;
      ca = 4'h1;
      cb = 4'h7;
      icnt = 4'h1;
      spl = 1'b1;
      trg = sas_pkg::TRIG_AUTO;
      aut = 1'b1;
      wait_irq();
      check(hf, 1'b1);
      read_chk(4'h0, 4'h1);
      clear_irq();
      wait_irq();
      check(hf, 1'b0);
      read_chk(4'h8, 4'h1);
      read_chk(4'h9, 4'h7);
      aut = 1'b0;
      clear_irq();
      $display("test split done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      check({se, busy, irq}, 3'h0);
      en = 1'b1;
      t_formats();
      t_scan();
      t_split();
      summarize();
   end
   initial
   begin
      #200000;
      fail_count++;
      summarize();
   end
endmodule
